/* aprw_pkg.sv */
// Package for the PIO sector-write command block: register map, field
// positions, opcodes, timing counts and the carrier structs.
// Assumes a 125 MHz system clock and a plain strobed register port.
package aprw_pkg;

  // ==========================================================================
  // Register index on the plain register port
  localparam logic [3:0] ADDR_TRANSFER_WORD = 4'h0;
  localparam logic [3:0] ADDR_FEATURE_PARAM = 4'h1; // Reads error_flags
  localparam logic [3:0] ADDR_SECTOR_COUNT = 4'h2;
  localparam logic [3:0] ADDR_SECTOR_NUMBER = 4'h3;
  localparam logic [3:0] ADDR_CYLINDER_LOW = 4'h4;
  localparam logic [3:0] ADDR_CYLINDER_HIGH = 4'h5;
  localparam logic [3:0] ADDR_DRIVE_HEAD = 4'h6;
  localparam logic [3:0] ADDR_OPCODE_ENTRY = 4'h7; // Reads device_state
  localparam logic [3:0] ADDR_DEVICE_CTRL = 4'h8;
  localparam logic [3:0] ADDR_BLOCK_SIZE = 4'h9;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_MULTIPLE = 8'hc5;
  localparam logic [7:0] OP_WRITE_MULTIPLE_EXT = 8'h39;
  localparam logic [7:0] OP_WRITE_SECTORS = 8'h30;
  localparam logic [7:0] OP_RETRY_MASK = 8'hfe;

  // ==========================================================================
  // Field positions
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_READY_BIT = 6;
  localparam int ST_SEEK_DONE_BIT = 4;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_ERR_BIT = 0;
  localparam int ERR_ABORT_BIT = 2;
  localparam int DH_LBA_BIT = 6;
  localparam int CTRL_HOB_BIT = 7;

  // ==========================================================================
  // Reset values and sizes
  localparam logic [7:0] DRIVE_HEAD_RST = 8'ha0;
  localparam logic [7:0] BLOCK_SIZE_RST = 8'h00;
  localparam logic [7:0] SECTOR_WORDS_M1 = 8'hff;
  localparam logic [16:0] COUNT28_ZERO = 17'h00100;
  localparam logic [16:0] COUNT48_ZERO = 17'h10000;

  // ==========================================================================
  // Timing
  localparam longint unsigned CLK_PERIOD_NS = 8;
  localparam longint unsigned BUSY_AFTER_WORD_NS = 5000;
  localparam longint unsigned BUSY_AFTER_WORD_CYC =
    BUSY_AFTER_WORD_NS / CLK_PERIOD_NS;
  localparam longint unsigned MEDIA_TIMEOUT_S = 30;
  localparam longint unsigned MEDIA_TIMEOUT_CYC =
    MEDIA_TIMEOUT_S * 1000000000 / CLK_PERIOD_NS;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } aprw_host_req_type;

  typedef struct packed {
    logic word_valid;
    logic [15:0] word;
    logic commit;
    logic [47:0] lba;
  } aprw_media_req_type;

  typedef struct packed {
    logic done;
    logic err;
  } aprw_media_rsp_type;

  typedef enum logic [1:0] {S_IDLE, S_XFER, S_MEDIA} aprw_state_type;

endpackage

/* aprw_watchdog.sv */
// Busy watchdog: counts cycles while run is high and flags expiry.
// Assumes run falls in the cycle after expiry, which restarts the count.
`timescale 1ns/1ns
module aprw_watchdog #(
  parameter longint unsigned LIMIT = 16,
  parameter int CNT_W = $clog2(LIMIT + 1)
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  output logic expired_out
);
  logic [CNT_W-1:0] cnt_q;

  initial begin
    if (LIMIT < 1) $error("aprw_watchdog: LIMIT must be at least 1");
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
    end else if (run_in && !expired_out) begin
      cnt_q <= cnt_q + 1'b1;
    end else begin
      cnt_q <= '0;
    end
  end

  assign expired_out = run_in && (cnt_q == CNT_W'(LIMIT - 1));
endmodule

/* aprw_write_cmd.sv */
// PIO sector-write command interpreter: task file, opcode decode, word
// intake, per-sector media handshake and completion reporting.
// Assumes a host that keeps to the data-request handshake and a media
// engine that answers each committed sector with done (and err).
//
// Summary of operation
// - Opcode C5h: multiple write, data in blocks, one interrupt per block.
// - Opcode 39h: extended multiple write with two-deep count and address.
// - Opcodes 30h and 31h both start the single-sector-interrupt write.
// - The retry bit in opcode bit 0 is ignored.
// - Sector data moves as 16-bit words, one word per data access.
// - Multiple writes interrupt once per configured block, not per sector.
// - 28-bit commands: count zero means 256 sectors.
// - Extended: count is previous:current bytes; zero means 65,536.
// - LBA mode: sector number is LBA 7:0, head field LBA 27:24.
// - LBA mode: cylinder low is LBA 15:8, cylinder high LBA 23:16.
// - Extended start address: current bytes low, previous bytes high.
// - Extended error address read back per high-order-byte select.
// - An uncorrectable error stops the write at the failing sector.
// - 28-bit completion: count holds sectors not transferred.
// - 28-bit completion: address registers hold the last sector written.
// - Busy within 5 us after the last word of each sector.
// - Busy clears with ready within 30 s, with interrupt except mid-block in multiple writes.
`timescale 1ns/1ns
module aprw_write_cmd
  import aprw_pkg::*;
#(
  parameter int SECTORS_PER_TRACK = 63,
  parameter int HEAD_COUNT = 16,
  parameter longint unsigned MEDIA_TIMEOUT = MEDIA_TIMEOUT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire aprw_host_req_type host_req_in,
  output logic [15:0] host_rdata_out,
  output aprw_media_req_type media_req_out,
  input wire aprw_media_rsp_type media_rsp_in,
  output logic intrq_out
);

  // ==========================================================================
  // Elaboration checks
  initial begin
    if (SECTORS_PER_TRACK < 1 || SECTORS_PER_TRACK > 255)
      $error("aprw_write_cmd: SECTORS_PER_TRACK out of range");
    if (HEAD_COUNT < 1 || HEAD_COUNT > 16)
      $error("aprw_write_cmd: HEAD_COUNT out of range");
    if (MEDIA_TIMEOUT < 1)
      $error("aprw_write_cmd: MEDIA_TIMEOUT must be at least 1");
    if (BUSY_AFTER_WORD_CYC < 1)
      $error("aprw_write_cmd: busy latency below one cycle");
  end

  localparam logic [7:0] SPT = 8'(SECTORS_PER_TRACK);
  localparam logic [3:0] LAST_HEAD = 4'(HEAD_COUNT - 1);

  // ==========================================================================
  // State
  aprw_state_type state_q, state_d;
  logic cmd_ext_q, cmd_mult_q;
  logic [15:0] cnt_q, feature_q;
  logic [47:0] addr_q;
  logic [7:0] dev_head_q, block_size_q, error_q;
  logic hob_q, err_st_q, intrq_q;
  logic [16:0] rem_q;
  logic [7:0] blk_left_q, word_cnt_q;
  logic [15:0] rdata_q;
  aprw_media_req_type media_q;

  // ==========================================================================
  // Decode
  logic wr, rd, tf_wr, op_write, is_single, is_mult, is_ext, accept;
  logic dwr, last_word, st_read, expired, media_ok, media_fail;
  logic [16:0] start_rem, rem_next;
  logic [7:0] op;
  logic [27:0] lba28_next;
  logic [7:0] chs_sect_next;
  logic [15:0] chs_cyl_next;
  logic [3:0] chs_head_next;
  logic [7:0] status;
  logic fin_ok, blk_end;

  assign wr = host_req_in.wr;
  assign rd = host_req_in.rd;
  assign op = host_req_in.wdata[7:0];
  // Command block writes are ignored while a command is running
  assign tf_wr = wr && (state_q == S_IDLE);
  assign op_write = tf_wr && (host_req_in.addr == ADDR_OPCODE_ENTRY);
  assign is_single = (op & OP_RETRY_MASK) == OP_WRITE_SECTORS;
  assign is_mult = op == OP_WRITE_MULTIPLE;
  assign is_ext = op == OP_WRITE_MULTIPLE_EXT;
  // Multiple writes need a block size; zero means multiple mode is off
  assign accept = is_single
    || ((is_mult || is_ext) && (block_size_q != 8'h00));

  // One word per data access, only while data request is up
  assign dwr = wr && (host_req_in.addr == ADDR_TRANSFER_WORD)
    && (state_q == S_XFER);
  assign last_word = dwr && (word_cnt_q == SECTOR_WORDS_M1);
  assign st_read = rd && (host_req_in.addr == ADDR_OPCODE_ENTRY);

  always_comb begin
    if (is_ext) begin
      start_rem = (cnt_q == 16'h0000) ? COUNT48_ZERO
        : {1'b0, cnt_q};
    end else begin
      start_rem = (cnt_q[7:0] == 8'h00) ? COUNT28_ZERO
        : {9'h000, cnt_q[7:0]};
    end
  end

  // Sectors in the next data-request block
  function automatic logic [7:0] block_len(input logic [16:0] rem,
                                           input logic mult,
                                           input logic [7:0] bsz);
    logic [7:0] len;
    len = 8'h01;
    if (mult) begin
      len = (rem < {9'h000, bsz}) ? rem[7:0] : bsz;
    end
    return len;
  endfunction

  aprw_watchdog #(
    .LIMIT(MEDIA_TIMEOUT)
  ) u_watchdog (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(state_q == S_MEDIA),
    .expired_out(expired)
  );

  assign media_ok = (state_q == S_MEDIA) && media_rsp_in.done
    && !media_rsp_in.err && !expired;
  assign media_fail = (state_q == S_MEDIA)
    && ((media_rsp_in.done && media_rsp_in.err) || expired);
  assign rem_next = rem_q - 17'h00001;
  assign fin_ok = media_ok && (rem_next == 17'h00000);
  assign blk_end = blk_left_q == 8'h01;

  // Next sector address in each addressing form
  assign lba28_next = {dev_head_q[3:0], addr_q[23:0]} + 28'h0000001;
  always_comb begin
    chs_sect_next = addr_q[7:0] + 8'h01;
    chs_head_next = dev_head_q[3:0];
    chs_cyl_next = addr_q[23:8];
    if (addr_q[7:0] >= SPT) begin
      chs_sect_next = 8'h01;
      if (dev_head_q[3:0] >= LAST_HEAD) begin
        chs_head_next = 4'h0;
        chs_cyl_next = addr_q[23:8] + 16'h0001;
      end else begin
        chs_head_next = dev_head_q[3:0] + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Command sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: begin
        if (op_write && accept) state_d = S_XFER;
      end
      S_XFER: begin
        if (last_word) state_d = S_MEDIA;
      end
      S_MEDIA: begin
        if (media_fail || fin_ok) begin
          state_d = S_IDLE;
        end else if (media_ok) begin
          state_d = S_XFER;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Sector and block counters
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_ext_q <= 1'b0;
      cmd_mult_q <= 1'b0;
      rem_q <= '0;
      blk_left_q <= '0;
      word_cnt_q <= '0;
    end else begin
      if (op_write && accept) begin
        cmd_ext_q <= is_ext;
        cmd_mult_q <= is_mult || is_ext;
        rem_q <= start_rem;
        blk_left_q <= block_len(start_rem, is_mult || is_ext, block_size_q);
        word_cnt_q <= '0;
      end else begin
        if (dwr) word_cnt_q <= word_cnt_q + 8'h01;
        if (media_ok) begin
          rem_q <= rem_next;
          blk_left_q <= blk_end
            ? block_len(rem_next, cmd_mult_q, block_size_q)
            : blk_left_q - 8'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Task file registers; count, feature and address bytes push the older byte into the high half
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      feature_q <= '0;
      addr_q <= '0;
      dev_head_q <= DRIVE_HEAD_RST;
      block_size_q <= BLOCK_SIZE_RST;
      hob_q <= 1'b0;
    end else if (tf_wr) begin
      unique case (host_req_in.addr)
        ADDR_FEATURE_PARAM: feature_q <= {feature_q[7:0], op};
        ADDR_SECTOR_COUNT: cnt_q <= {cnt_q[7:0], op};
        ADDR_SECTOR_NUMBER: begin
          addr_q[31:24] <= addr_q[7:0];
          addr_q[7:0] <= op;
        end
        ADDR_CYLINDER_LOW: begin
          addr_q[39:32] <= addr_q[15:8];
          addr_q[15:8] <= op;
        end
        ADDR_CYLINDER_HIGH: begin
          addr_q[47:40] <= addr_q[23:16];
          addr_q[23:16] <= op;
        end
        ADDR_DRIVE_HEAD: dev_head_q <= op;
        ADDR_DEVICE_CTRL: hob_q <= op[CTRL_HOB_BIT];
        ADDR_BLOCK_SIZE: block_size_q <= op;
        default: ;
      endcase
    end else if (media_ok && !fin_ok) begin
      // Advance only when another sector follows, so that completion
      // leaves the last written sector in place
      if (cmd_ext_q) begin
        addr_q <= addr_q + 48'h000000000001;
      end else if (dev_head_q[DH_LBA_BIT]) begin
        addr_q[23:0] <= lba28_next[23:0];
        dev_head_q[3:0] <= lba28_next[27:24];
      end else begin
        addr_q[7:0] <= chs_sect_next;
        addr_q[23:8] <= chs_cyl_next;
        dev_head_q[3:0] <= chs_head_next;
      end
    end else if (fin_ok || media_fail) begin
      // Error keeps the failing sector's address in place
      if (cmd_ext_q) begin
        cnt_q <= media_fail ? rem_q[15:0] : 16'h0000;
      end else begin
        cnt_q[7:0] <= media_fail ? rem_q[7:0] : 8'h00;
      end
    end
  end

  // ==========================================================================
  // Error report and interrupt request; a new event beats a status read
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      error_q <= '0;
      err_st_q <= 1'b0;
    end else if (op_write) begin
      error_q <= '0;
      error_q[ERR_ABORT_BIT] <= !accept;
      err_st_q <= !accept;
    end else if (media_fail) begin
      error_q[ERR_ABORT_BIT] <= 1'b1;
      err_st_q <= 1'b1;
    end
  end

  logic intrq_set;
  assign intrq_set = (op_write && !accept) || media_fail || fin_ok
    || (media_ok && blk_end);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      intrq_q <= 1'b0;
    end else begin
      intrq_q <= intrq_set || (intrq_q && !st_read && !op_write);
    end
  end

  // ==========================================================================
  // Register reads; data stand in the cycle after the strobe only
  always_comb begin
    status = '0;
    status[ST_BUSY_BIT] = state_q == S_MEDIA;
    status[ST_READY_BIT] = 1'b1;
    status[ST_SEEK_DONE_BIT] = 1'b1;
    status[ST_DRQ_BIT] = state_q == S_XFER;
    status[ST_ERR_BIT] = err_st_q;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= '0;
    end else if (!rd) begin
      rdata_q <= '0;
    end else begin
      unique case (host_req_in.addr)
        ADDR_FEATURE_PARAM: rdata_q <= {8'h00, error_q};
        ADDR_SECTOR_COUNT: rdata_q <= {8'h00,
          hob_q ? cnt_q[15:8] : cnt_q[7:0]};
        ADDR_SECTOR_NUMBER: rdata_q <= {8'h00,
          hob_q ? addr_q[31:24] : addr_q[7:0]};
        ADDR_CYLINDER_LOW: rdata_q <= {8'h00,
          hob_q ? addr_q[39:32] : addr_q[15:8]};
        ADDR_CYLINDER_HIGH: rdata_q <= {8'h00,
          hob_q ? addr_q[47:40] : addr_q[23:16]};
        ADDR_DRIVE_HEAD: rdata_q <= {8'h00, dev_head_q};
        ADDR_OPCODE_ENTRY: rdata_q <= {8'h00, status};
        ADDR_DEVICE_CTRL: rdata_q <= {8'h00, hob_q, 7'h00};
        ADDR_BLOCK_SIZE: rdata_q <= {8'h00, block_size_q};
        default: rdata_q <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Media side: words are registered unchanged, commit marks a sector end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      media_q <= '0;
    end else begin
      media_q.word_valid <= dwr;
      if (dwr) media_q.word <= host_req_in.wdata;
      media_q.commit <= last_word;
      if (last_word) begin
        if (cmd_ext_q) begin
          media_q.lba <= addr_q;
        end else if (dev_head_q[DH_LBA_BIT]) begin
          media_q.lba <= {20'h00000, dev_head_q[3:0], addr_q[23:0]};
        end else begin
          media_q.lba <= {16'h0000, addr_q[23:8], 4'h0,
            dev_head_q[3:0], addr_q[7:0]};
        end
      end
    end
  end

  assign host_rdata_out = rdata_q;
  assign media_req_out = media_q;
  assign intrq_out = intrq_q;

endmodule

/* aprw_write_cmd_properties.sv */
// Checker for the sector-write block: timing relations at its ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module aprw_write_cmd_properties
  import aprw_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire aprw_host_req_type host_req_in,
  input wire logic [15:0] host_rdata_out,
  input wire aprw_media_req_type media_req_out,
  input wire aprw_media_rsp_type media_rsp_in,
  input wire logic intrq_out
);
  // ==========================================================
  // Words handed on in the current sector
  logic [8:0] wcnt_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wcnt_q <= 9'h000;
    end else if (media_req_out.commit) begin
      wcnt_q <= 9'h000;
    end else if (media_req_out.word_valid) begin
      wcnt_q <= wcnt_q + 9'h001;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_status_rd;
    host_req_in.rd && host_req_in.addr == ADDR_OPCODE_ENTRY;
  endsequence
  sequence s_fail_done;
    media_rsp_in.done && media_rsp_in.err;
  endsequence
  sequence s_last_word;
    media_req_out.word_valid && wcnt_q == 9'h0ff;
  endsequence
  property p_rdata_idle;
    !host_req_in.rd |=> host_rdata_out == 16'h0000;
  endproperty
  property p_status_ready;
    s_status_rd |=> host_rdata_out[ST_READY_BIT] &&
      host_rdata_out[ST_SEEK_DONE_BIT];
  endproperty
  property p_word_copy;
    media_req_out.word_valid |-> $past(host_req_in.wr) &&
      $past(host_req_in.addr) == ADDR_TRANSFER_WORD &&
      media_req_out.word == $past(host_req_in.wdata);
  endproperty
  property p_commit_count;
    media_req_out.commit |-> wcnt_q == 9'h100 ||
      (wcnt_q == 9'h0ff && media_req_out.word_valid);
  endproperty
  property p_busy_after_last;
    s_last_word |-> ##[0:1] media_req_out.commit;
  endproperty
  property p_refuse_in_busy;
    media_req_out.commit |=> !media_req_out.word_valid [*3];
  endproperty
  property p_fail_intrq;
    s_fail_done |=> intrq_out;
  endproperty
  property p_fail_stops;
    s_fail_done |=> !media_req_out.word_valid [*4];
  endproperty
  property p_intrq_clear;
    s_status_rd ##0 (!media_rsp_in.done && !host_req_in.wr) |=> !intrq_out;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read");
  a_status_ready: assert property (p_status_ready)
    else $error("status lacks ready");
  a_word_copy: assert property (p_word_copy)
    else $error("media word differs from host word");
  a_commit_count: assert property (p_commit_count)
    else $error("sector committed with wrong word count");
  a_busy_after_last: assert property (p_busy_after_last)
    else $error("no commit after last word");
  a_refuse_in_busy: assert property (p_refuse_in_busy)
    else $error("word taken while busy");
  a_fail_intrq: assert property (p_fail_intrq)
    else $error("no interrupt after media failure");
  a_fail_stops: assert property (p_fail_stops)
    else $error("word taken after failure");
  a_intrq_clear: assert property (p_intrq_clear)
    else $error("interrupt not cleared by status read");
endmodule

bind aprw_write_cmd aprw_write_cmd_properties u_chk (
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .host_req_in(host_req_in),
  .host_rdata_out(host_rdata_out),
  .media_req_out(media_req_out),
  .media_rsp_in(media_rsp_in),
  .intrq_out(intrq_out)
);

/* aprw_media_model.sv */
// Media engine model: answers each committed sector after a delay.
// Assumes delay and failure are set by the bench before the commit.
`timescale 1ns/1ns
module aprw_media_model
  import aprw_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire aprw_media_req_type req_in,
  input wire logic [15:0] delay_in,
  input wire logic fail_in,
  output aprw_media_rsp_type rsp_out
);
  // ==========================================================
  // Sector answer
  logic busy_q;
  logic err_q;
  logic [15:0] cnt_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_q <= 1'b0;
      err_q <= 1'b0;
      cnt_q <= 16'h0000;
      rsp_out <= '0;
    end else begin
      rsp_out <= '0;
      if (req_in.commit) begin
        busy_q <= 1'b1;
        cnt_q <= 16'h0000;
        err_q <= fail_in;
      end else if (busy_q && cnt_q == delay_in) begin
        // Long delays let the device's own busy limit run out first
        busy_q <= 1'b0;
        rsp_out <= '{done: 1'b1, err: err_q};
      end else if (busy_q) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule

/* aprw_write_cmd_tb_top.sv */
// Testbench for the sector-write block with a media engine model.
// Assumes the checker is bound in and a short busy limit of 50.
`timescale 1ns/1ns
module aprw_write_cmd_tb_top
  import aprw_pkg::*;
;
  // ==========================================================
  // Signals and instances
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  aprw_host_req_type req = '0;
  aprw_media_req_type mreq;
  aprw_media_rsp_type mrsp;
  logic [15:0] rdata;
  logic irq;
  logic [15:0] dly = 16'h0003;
  logic fail = 1'b0;
  logic rd_seen = 1'b0;
  logic [31:0] seed = 32'h00002ef6;
  logic [15:0] rd_exp[$];
  logic [47:0] lba_exp[$];
  logic [7:0] ops[3] = '{8'hc5, 8'h39, 8'h20};
  int miscompares = 0;
  int tests_run = 0;

  always #4 clk_in = ~clk_in;

  aprw_write_cmd #(.MEDIA_TIMEOUT(50)) dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .host_req_in(req),
    .host_rdata_out(rdata), .media_req_out(mreq),
    .media_rsp_in(mrsp), .intrq_out(irq));
  aprw_media_model u_media (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .req_in(mreq),
    .delay_in(dly), .fail_in(fail), .rsp_out(mrsp));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk16(input string what, input logic [15:0] e, s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic chk48(input string what, input logic [47:0] e, s);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    rd_exp.push_back(e);
    @(posedge clk_in);
  endtask
  task automatic idle();
    req <= '0;
    @(posedge clk_in);
  endtask
  task automatic setr(input logic [7:0] sn, cl, ch, cnt);
    wr(ADDR_SECTOR_NUMBER, {8'h00, sn});
    wr(ADDR_CYLINDER_LOW, {8'h00, cl});
    wr(ADDR_CYLINDER_HIGH, {8'h00, ch});
    wr(ADDR_SECTOR_COUNT, {8'h00, cnt});
  endtask
  task automatic rdb(input logic [7:0] sn, cl, ch, cnt);
    rd(ADDR_SECTOR_NUMBER, {8'h00, sn});
    rd(ADDR_CYLINDER_LOW, {8'h00, cl});
    rd(ADDR_CYLINDER_HIGH, {8'h00, ch});
    rd(ADDR_SECTOR_COUNT, {8'h00, cnt});
  endtask
  task automatic wait_ev();
    int n;
    n = 0;
    while (mrsp.done !== 1'b1 && irq !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    chk16("completion", 16'h0001, {15'h0000, n < 300});
  endtask
  task automatic run(input logic [7:0] op, input int n, blk, bad,
      input logic [47:0] base, input logic me);
    logic last;
    logic endb;
    wr(ADDR_OPCODE_ENTRY, {8'h00, op});
    for (int s = 0; s < n; s++) begin
      fail <= me && s == bad;
      lba_exp.push_back(base + 48'(s));
      repeat (256) begin
        wr(ADDR_TRANSFER_WORD, seed[15:0]);
        seed = xs(seed);
      end
      // One word too many, sent while the device turns busy
      wr(ADDR_TRANSFER_WORD, 16'h0000);
      idle();
      wait_ev();
      @(posedge clk_in);
      last = s == n - 1 || s == bad;
      endb = last || (s + 1) % blk == 0;
      chk16("interrupt", {15'h0000, endb}, {15'h0000, irq});
      if (s == bad) begin
        wr(ADDR_TRANSFER_WORD, 16'h5a5a);
        rd(ADDR_OPCODE_ENTRY, 16'h0051);
        rd(ADDR_FEATURE_PARAM, 16'h0004);
        break;
      end
      if (endb) rd(ADDR_OPCODE_ENTRY, last ? 16'h0050 : 16'h0058);
    end
    idle();
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Result monitor and watchdog
  always @(posedge clk_in) begin
    rd_seen <= req.rd;
    if (rd_seen) chk16("read data", rd_exp.pop_front(), rdata);
    if (mreq.commit) chk48("sector address",
      lba_exp.size() != 0 ? lba_exp.pop_front() : 'x, mreq.lba);
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    $display("Error run time expected end seen hang");
    stop_test();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    rd(ADDR_DRIVE_HEAD, 16'h00a0);
    rd(ADDR_BLOCK_SIZE, 16'h0000);
    rd(ADDR_TRANSFER_WORD, 16'h0000);
    rd(4'hf, 16'h0000);
    rdb(8'h00, 8'h00, 8'h00, 8'h00);
    // Block size zero: both multiple writes abort, as does a stray code
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_OPCODE_ENTRY, {8'h00, ops[i]});
      idle();
      wait_ev();
      rd(ADDR_OPCODE_ENTRY, 16'h0051);
      rd(ADDR_FEATURE_PARAM, 16'h0004);
      idle();
      chk16("interrupt", 16'h0000, {15'h0000, irq});
    end
    wr(ADDR_BLOCK_SIZE, 16'h0002);
    rd(ADDR_BLOCK_SIZE, 16'h0002);
    wr(ADDR_DRIVE_HEAD, 16'h00e5);
    setr(8'hff, 8'h34, 8'h12, 8'h02);
    run(8'h30, 2, 1, -1, 48'h0000_0512_34ff, 1'b0);
    rdb(8'h00, 8'h35, 8'h12, 8'h00);
    rd(ADDR_DRIVE_HEAD, 16'h00e5);
    wr(ADDR_SECTOR_COUNT, 16'h0001);
    run(8'h31, 1, 1, -1, 48'h0000_0512_3500, 1'b0);
    // Cylinder-head-sector form: head 3, sectors 3eh then 3fh
    wr(ADDR_DRIVE_HEAD, 16'h00a3);
    setr(8'h3e, 8'h34, 8'h12, 8'h02);
    run(8'h30, 2, 1, -1, 48'h0000_1234_033e, 1'b0);
    rdb(8'h3f, 8'h34, 8'h12, 8'h00);
    rd(ADDR_DRIVE_HEAD, 16'h00a3);
    wr(ADDR_DRIVE_HEAD, 16'h00e0);
    setr(8'h10, 8'h00, 8'h00, 8'h00);
    dly <= 16'h001e;
    run(8'hc5, 256, 2, 1, 48'h10, 1'b1);
    rdb(8'h11, 8'h00, 8'h00, 8'hff);
    wr(ADDR_SECTOR_COUNT, 16'h0003);
    run(8'hc5, 3, 2, -1, 48'h11, 1'b0);
    rdb(8'h13, 8'h00, 8'h00, 8'h00);
    dly <= 16'h0003;
    setr(8'h56, 8'h34, 8'h12, 8'h00);
    setr(8'hbc, 8'h9a, 8'h78, 8'h00);
    run(8'h39, 65536, 2, 1, 48'h1234_5678_9abc, 1'b1);
    rdb(8'hbd, 8'h9a, 8'h78, 8'hff);
    wr(ADDR_DEVICE_CTRL, 16'h0080);
    rdb(8'h56, 8'h34, 8'h12, 8'hff);
    wr(ADDR_DEVICE_CTRL, 16'h0000);
    // Media answer slower than the busy limit
    dly <= 16'h0100;
    wr(ADDR_SECTOR_COUNT, 16'h0001);
    run(8'h30, 1, 1, 0, 48'h0000_0078_9abd, 1'b0);
    rd(ADDR_SECTOR_COUNT, 16'h0001);
    idle();
    idle();
    stop_test();
  end
endmodule
